// file: verilog/irq_vector_map.sv
// irq_vector_map: folds peripheral requests onto irq lines, picks the
// lowest pending irq and its vector, and raises wake from low power.
// assumes requests are levels held until serviced, synchronous to clk_sys.
// assumes the core holds mode steady for as long as it sleeps.
`timescale 1ns/100ps
module irq_vector_map (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irq_map_pkg::power_mode_e mode,
  input wire logic trap_req,
  input wire logic flash_req,
  input wire logic [1:0] xfer01_half_req,
  input wire logic [1:0] xfer01_done_req,
  input wire logic [1:0] xfer23_half_req,
  input wire logic [1:0] xfer23_done_req,
  input wire logic rtc_alarm_req,
  input wire logic rtc_wakeup_req,
  input wire logic [2:0] rtc_tamper_req,
  input wire logic [1:0] port_ef_req,
  input wire logic supply_level_detector_req,
  input wire logic [1:0] port_bg_req,
  input wire logic [1:0] port_dh_req,
  input wire logic [7:0] pin_event_interrupt_req,
  input wire logic display_req,
  input wire logic clk_switch_req,
  input wire logic clock_failure_monitor_req,
  input wire logic advanced_timer_break_req,
  input wire logic converter_req,
  output logic [irq_map_pkg::IRQ_COUNT-1:0] irq_pending_reg,
  output logic irq_valid_reg,
  output logic [irq_map_pkg::IRQ_W-1:0] irq_num_reg,
  output logic [irq_map_pkg::VEC_W-1:0] vector_reg,
  output logic wake_reg
);
  import irq_map_pkg::*;

  // folded irq lines, bit n is irq n; bit 0 stays low, it is reserved
  logic [IRQ_COUNT-1:0] irq_lines;
  // per-pin lines before they land on irq 8 to 15
  logic [7:0] pin_lines;
  // qualifier column picked by the present mode
  logic [IRQ_COUNT-1:0] allow;
  // pending lines that may end the present low-power mode
  logic [IRQ_COUNT-1:0] wake_lines;
  // high through the first edge after reset is released, so the core
  // sees the reset vector before any irq vector
  logic reset_fetch_reg;
  // lowest pending irq number, 0 when nothing is pending
  logic [IRQ_W-1:0] lowest_num;
  // some irq 1 to 17 is pending
  logic any_pending;
  // next values of the output flops
  logic irq_valid_next;
  logic [IRQ_W-1:0] irq_num_next;
  logic [VEC_W-1:0] vector_next;
  logic wake_next;

  // irq number to vector address, used by the irq vector path only
  function automatic logic [VEC_W-1:0] vec_of(input logic [IRQ_W-1:0] n);
    vec_of = VEC_IRQ_BASE + VEC_STEP * {{(VEC_W-IRQ_W){1'b0}}, n};
  endfunction

  // lowest set bit above reserved irq 0; a downward scan keeps the
  // last hit, so the smallest number wins without a priority tree
  function automatic logic [IRQ_W-1:0] lowest_of(
    input logic [IRQ_COUNT-1:0] lines
  );
    lowest_of = '0;
    for (int i = IRQ_COUNT - 1; i > 0; i--) begin
      if (lines[i]) begin
        lowest_of = IRQ_W'(i);
      end
    end
  endfunction

  // true in every mode that stops the core and so needs a wake
  function automatic logic is_low_power(input power_mode_e m);
    is_low_power = (m != MODE_RUN);
  endfunction

  // fold shared sources onto their irq lines; irq 0 is reserved
  always_comb begin
    irq_lines = '0;
    // flash and transfer lines wake only from the wait modes
    irq_lines[IRQ_FLASH] = flash_req;
    irq_lines[IRQ_XFER_01] = |{xfer01_half_req, xfer01_done_req};
    irq_lines[IRQ_XFER_23] = |{xfer23_half_req, xfer23_done_req};
    irq_lines[IRQ_RTC] = rtc_alarm_req | rtc_wakeup_req
      | (|rtc_tamper_req);
    irq_lines[IRQ_PORT_EF] = (|port_ef_req)
      | supply_level_detector_req;
    // port groups share a line; the handler reads the port to tell
    irq_lines[IRQ_PORT_BG] = |port_bg_req;
    irq_lines[IRQ_PORT_DH] = |port_dh_req;
    irq_lines[IRQ_PIN0 +: 8] = pin_lines;
    // the display line is wait-only; its qualifier bit sees to that
    irq_lines[IRQ_DISPLAY] = display_req;
    // clock, timer break and converter events all land on irq 17
    irq_lines[IRQ_CLK_TMR] = clk_switch_req | clock_failure_monitor_req
      | advanced_timer_break_req | converter_req;
  end

  // one dedicated line per pin, never shared with a port group;
  // the lines are gathered here and placed by one part-select
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign pin_lines[g] = pin_event_interrupt_req[g];
    end
  endgenerate

  wake_qualifier u_wake (
    .mode(mode),
    .allow(allow)
  );

  // sources whose qualifier is off for this mode are masked here
  assign wake_lines = irq_lines & allow;

  // priority search over every pending irq, display and irq 17 included
  assign lowest_num = lowest_of(irq_lines);
  assign any_pending = |irq_lines;

  // next vector: reset fetch first, then the trap, then lowest irq;
  // with nothing pending the vector rests on irq 0 and valid stays low
  // a trap that meets the reset fetch shows on the next edge if held
  always_comb begin
    irq_valid_next = any_pending;
    irq_num_next = lowest_num;
    vector_next = vec_of(lowest_num);
    if (reset_fetch_reg) begin
      irq_valid_next = 1'b0;
      irq_num_next = '0;
      vector_next = VEC_RESET;
    end else if (trap_req) begin
      irq_valid_next = 1'b0;
      irq_num_next = '0;
      vector_next = VEC_TRAP;
    end
  end

  // run mode never asks for a wake, whatever is pending
  always_comb begin
    wake_next = 1'b0;
    if (is_low_power(mode)) begin
      wake_next = |wake_lines;
    end
  end

  // pending image registered so outputs come from flops;
  // it lags the request lines by one edge, as every output does
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_pending_reg <= '0;
    end else begin
      irq_pending_reg <= irq_lines;
    end
  end

  // first cycle after reset presents the reset vector, even when a
  // source is already high as reset is released
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_fetch_reg <= 1'b1;
    end else begin
      reset_fetch_reg <= 1'b0;
    end
  end

  // valid marks an irq vector, never the reset or the trap vector;
  // low under reset so no irq is taken before the reset fetch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_valid_reg <= 1'b0;
    end else begin
      irq_valid_reg <= irq_valid_next;
    end
  end

  // irq number of the vector presented, 0 for reset and trap;
  // reserved irq 0 doubles as the none marker
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_num_reg <= '0;
    end else begin
      irq_num_reg <= irq_num_next;
    end
  end

  // vector held in a flop so the core fetches from a stable address;
  // it changes only on an edge, never in mid-cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vector_reg <= VEC_RESET;
    end else begin
      vector_reg <= vector_next;
    end
  end

  // wake only where the mode's qualifier allows; reset ends any mode,
  // so wake stands high while reset is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_reg <= 1'b1;
    end else begin
      wake_reg <= wake_next;
    end
  end
endmodule

// file: verilog/irq_map_pkg.sv
// irq_map_pkg: irq numbers, vector addresses and wake qualifiers.
// assumes a 24-bit linear code address space with vectors at 0x008000 up.
package irq_map_pkg;
  localparam int IRQ_COUNT = 18;
  localparam int IRQ_W = 5;
  localparam int VEC_W = 24;
  localparam logic [VEC_W-1:0] VEC_RESET = 24'h00_8000;
  localparam logic [VEC_W-1:0] VEC_TRAP = 24'h00_8004;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 24'h00_8008;
  localparam logic [VEC_W-1:0] VEC_STEP = 24'h00_0004;
  localparam logic [IRQ_W-1:0] IRQ_FLASH = 5'h01;
  localparam logic [IRQ_W-1:0] IRQ_XFER_01 = 5'h02;
  localparam logic [IRQ_W-1:0] IRQ_XFER_23 = 5'h03;
  localparam logic [IRQ_W-1:0] IRQ_RTC = 5'h04;
  localparam logic [IRQ_W-1:0] IRQ_PORT_EF = 5'h05;
  localparam logic [IRQ_W-1:0] IRQ_PORT_BG = 5'h06;
  localparam logic [IRQ_W-1:0] IRQ_PORT_DH = 5'h07;
  localparam logic [IRQ_W-1:0] IRQ_PIN0 = 5'h08;
  localparam logic [IRQ_W-1:0] IRQ_DISPLAY = 5'h10;
  localparam logic [IRQ_W-1:0] IRQ_CLK_TMR = 5'h11;
  // wake qualifier bits per irq: halt, active-halt, int-wait, event-wait
  localparam logic [IRQ_COUNT-1:0] WAKE_HALT = 18'h0_FFF0;
  localparam logic [IRQ_COUNT-1:0] WAKE_AHALT = 18'h0_FFF0;
  localparam logic [IRQ_COUNT-1:0] WAKE_IWAIT = 18'h3_FFFE;
  localparam logic [IRQ_COUNT-1:0] WAKE_EWAIT = 18'h3_FFFE;
  typedef enum logic [2:0] {
    MODE_RUN, MODE_HALT, MODE_AHALT, MODE_IWAIT, MODE_EWAIT
  } power_mode_e;
endpackage

// file: verilog/wake_qualifier.sv
// wake_qualifier: picks the qualifier set for the current low-power mode.
// assumes mode is stable for the cycle it is sampled in.
`timescale 1ns/100ps
module wake_qualifier (
  input wire irq_map_pkg::power_mode_e mode,
  output logic [irq_map_pkg::IRQ_COUNT-1:0] allow
);
  import irq_map_pkg::*;
  // four separate qualifier columns; run mode never needs a wake
  always_comb begin
    case (mode)
      MODE_HALT: allow = WAKE_HALT;
      MODE_AHALT: allow = WAKE_AHALT;
      MODE_IWAIT: allow = WAKE_IWAIT;
      MODE_EWAIT: allow = WAKE_EWAIT;
      default: allow = '0;
    endcase
  end
endmodule

// file: verification/irq_map_assertions.sv
// irq_map_chk: timing checks on the irq map outputs.
// assumes outputs follow inputs one clk_sys edge later.
`timescale 1ns/100ps
module irq_map_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irq_map_pkg::power_mode_e mode,
  input wire logic trap_req,
  input wire logic flash_req,
  input wire logic [7:0] pin_event_interrupt_req,
  input wire logic [17:0] irq_pending_reg,
  input wire logic irq_valid_reg,
  input wire logic [4:0] irq_num_reg,
  input wire logic [23:0] vector_reg,
  input wire logic wake_reg
);
  import irq_map_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_vec_step: assert property (!$past(rst) && irq_valid_reg |->
    vector_reg == VEC_IRQ_BASE + VEC_STEP * 24'(irq_num_reg))
    else $error("vector not base plus four per irq");
  a_lowest_wins: assert property (irq_valid_reg |->
    irq_pending_reg[irq_num_reg] &&
    (irq_pending_reg & ((18'h1 << irq_num_reg) - 18'h1)) == 18'h0)
    else $error("irq number not lowest pending");
  a_run_quiet: assert property (!rst && mode == MODE_RUN |=>
    !wake_reg) else $error("wake raised in run mode");
  a_halt_wake: assert property (!$past(rst) &&
    $past(mode) inside {MODE_HALT, MODE_AHALT} |->
    wake_reg == |irq_pending_reg[15:4]) else $error("halt wake wrong");
  a_wait_wake: assert property (!$past(rst) &&
    $past(mode) inside {MODE_IWAIT, MODE_EWAIT} |->
    wake_reg == |irq_pending_reg[17:1]) else $error("wait wake wrong");
  a_flash_num: assert property (!rst && !$past(rst) && flash_req &&
    !trap_req |=> irq_num_reg == IRQ_FLASH)
    else $error("flash not irq 1");
  a_pin_image: assert property (!rst |=> irq_pending_reg[15:8] ==
    $past(pin_event_interrupt_req)) else $error("pin lines not irq 8-15");
  a_trap_vec: assert property (!rst && !$past(rst) && trap_req |=>
    vector_reg == VEC_TRAP && !irq_valid_reg)
    else $error("trap vector wrong");
  c_wake: cover property (wake_reg && mode == MODE_HALT);
  c_trap: cover property (trap_req ##1 irq_pending_reg != 18'h0);
  c_wait: cover property (irq_valid_reg && mode == MODE_EWAIT);
endmodule
bind irq_vector_map irq_map_chk chk_i (.*);

// file: verification/irq_source_model.sv
// irq_source_model: peripheral request lines behind the irq map.
// assumes the bench picks up to two sources by index.
`timescale 1ns/100ps
module irq_source_model (
  input wire logic [5:0] src_a,
  input wire logic [5:0] src_b,
  input wire logic [1:0] fire,
  output logic [33:0] req
);
  // levels only; an unpicked source reads low, as a quiet peripheral does
  assign req = (fire[0] ? 34'h1 << src_a : 34'h0) |
    (fire[1] ? 34'h1 << src_b : 34'h0);
endmodule

// file: verification/testbench.sv
// testbench: every source in every mode, then priority and reset cases.
// assumes the source model and a 50 ns clk_sys.
`timescale 1ns/100ps
module testbench;
  import irq_map_pkg::*;
  logic clk_sys, rst, trap_req, valid, wake;
  power_mode_e mode;
  logic [5:0] src_a, src_b;
  logic [1:0] fire;
  logic [33:0] req;
  logic [17:0] pend;
  logic [4:0] num;
  logic [23:0] vec;
  int failures, tests_run;
  // expected irq for each source index, lsb first
  byte rows[34] = '{1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 4, 5, 5, 5, 6, 6,
    7, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 17, 17, 17};
  irq_source_model src_m (.src_a(src_a), .src_b(src_b), .fire(fire), .req(req));
  irq_vector_map uut (.clk_sys(clk_sys), .rst(rst), .mode(mode),
    .trap_req(trap_req), .flash_req(req[0]), .xfer01_half_req(req[2:1]),
    .xfer01_done_req(req[4:3]), .xfer23_half_req(req[6:5]),
    .xfer23_done_req(req[8:7]), .rtc_alarm_req(req[9]),
    .rtc_wakeup_req(req[10]), .rtc_tamper_req(req[13:11]),
    .port_ef_req(req[15:14]), .supply_level_detector_req(req[16]),
    .port_bg_req(req[18:17]), .port_dh_req(req[20:19]),
    .pin_event_interrupt_req(req[28:21]), .display_req(req[29]),
    .clk_switch_req(req[30]), .clock_failure_monitor_req(req[31]),
    .advanced_timer_break_req(req[32]), .converter_req(req[33]),
    .irq_pending_reg(pend), .irq_valid_reg(valid), .irq_num_reg(num),
    .vector_reg(vec), .wake_reg(wake));
  // shared compare and closing
  task automatic chk(logic [17:0] p, logic [4:0] n, logic w, logic v,
    logic [23:0] e);
    tests_run++;
    if ({pend, num, wake, valid, vec} !== {p, n, w, v, e}) begin
      failures++;
      $display("mismatch %0t num %0d wake %b vec %h", $time, num, wake, vec);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // inputs change on an edge, registered outputs settle one edge later
  task automatic drive(int m, int a, int b, logic [1:0] f, logic t);
    @(posedge clk_sys);
    mode <= power_mode_e'(m);
    src_a <= 6'(a);
    src_b <= 6'(b);
    fire <= f;
    trap_req <= t;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1;
    mode = MODE_RUN;
    {trap_req, fire, src_a, src_b} = '0;
    repeat (4) @(posedge clk_sys);
    chk(18'h0, 5'h00, 1'b1, 1'b0, VEC_RESET);
    rst <= 0;
    // row loop: each source alone in each of the five modes
    foreach (rows[i]) for (int m = 0; m < 5; m++) begin
      drive(m, i, 0, 2'h1, 1'b0);
      chk(18'h1 << rows[i], 5'(rows[i]), m > 2 || (m > 0 &&
        rows[i] inside {[4:15]}), 1'b1, VEC_IRQ_BASE + VEC_STEP * 24'(rows[i]));
    end
    // halt: flash cannot wake but pin 7 can, flash still wins the vector
    drive(1, 28, 0, 2'h3, 1'b0);
    chk(18'h0_8002, 5'h01, 1'b1, 1'b1, 24'h00_800C);
    drive(1, 28, 0, 2'h3, 1'b1);
    chk(18'h0_8002, 5'h00, 1'b1, 1'b0, VEC_TRAP);
    // reset in mid-run with requests still up
    @(posedge clk_sys);
    rst <= 1;
    @(posedge clk_sys);
    #1 chk(18'h0, 5'h00, 1'b1, 1'b0, VEC_RESET);
    @(posedge clk_sys);
    rst <= 0;
    // first edge after release: reset vector beats the held trap
    @(posedge clk_sys);
    #1 chk(18'h0_8002, 5'h00, 1'b1, 1'b0, VEC_RESET);
    drive(3, 21, 0, 2'h1, 1'b0);
    chk(18'h0_0100, 5'h08, 1'b1, 1'b1, 24'h00_8028);
    close_out;
  end
endmodule
